// *** cst_status_top.sv ***
`timescale 1ns/100ps
// Overview of operation
// - mode bit 0 is hardware-only, 1 while in initialization mode
// - mode bit 1 is hardware-only, 1 while sleeping, 0 after leaving sleep
// - mode bit 2 set on error event, cleared only by writing 1
// - mode bit 3 set on start-of-frame wakeup while sleeping, write 1 clears
// - mode bit 4 set entering sleep raising interrupt; cleared leaving sleep or write 1
// - mode bit 8 reads 1 while transmitting
// - mode bit 9 reads 1 while receiving
// - mode bit 10 returns last sampled receive pin value
// - mode bit 11 returns present receive pin level
// - request-done flag set at finish, cleared by new request or write 1
// - success flag set on success, 0 after failure, write 1 clears
// - arbitration-lost flag set on lost arbitration, write 1 clears
// - mailbox 0 failure flag set on failed transmission, write 1 clears
// - writing 1 to abort bit aborts pending request; ignored if none pending
// - mailbox 2 has the same flags at bits 16 to 19 and 23
// - bits 26 to 28 read 1 while mailbox 0 to 2 is empty
// - init request enters initialization; clearing it returns to normal, or to sleep if sleep request is set
module cst_status_top #(
	parameter int unsigned NUM_MB = 3 // transmit mailboxes
) (
	input wire logic ref_clk, // 10 MHz peripheral clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output logic irq, // level interrupt
	input wire logic rx_pin, // receive pin level
	input wire logic rx_sample, // bit sample point pulse
	input wire logic err_event, // error interrupt event pulse
	input wire logic tx_active, // core is transmitting
	input wire logic rx_active, // core is receiving
	input wire logic [NUM_MB-1:0] mb_new_req, // new transmit request
	input wire logic [NUM_MB-1:0] mb_ok, // attempt succeeded
	input wire logic [NUM_MB-1:0] mb_fail, // request failed
	input wire logic [NUM_MB-1:0] mb_arb_lost, // arbitration lost
	input wire logic [NUM_MB-1:0] mb_abort_done, // message removed
	output logic [NUM_MB-1:0] mb_abort_req, // abort request to core
	output logic init_mode, // controller in initialization
	output logic sleep_mode // controller asleep
);
	cst_pkg::cst_mode_t mode_q;
	cst_pkg::cst_mode_t mode_d;
	logic [31:0] ctrl_q;
	logic err_flag_q;
	logic wake_flag_q;
	logic sleep_irq_q;
	logic tx_now_q;
	logic rx_now_q;
	logic rx_last_q;
	logic rx_level_q;
	logic [cst_pkg::IRQ_WIDTH-1:0] irq_stat_q;
	logic [cst_pkg::IRQ_WIDTH-1:0] irq_mask_q;
	logic [cst_pkg::IRQ_WIDTH-1:0] irq_evt;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_tx;
	logic wr_mask;
	logic rd_stat;
	logic sof_wake;
	logic sleep_enter;
	logic sleep_leave;
	logic [NUM_MB-1:0] mb_done;
	logic [NUM_MB-1:0] mb_okf;
	logic [NUM_MB-1:0] mb_arb;
	logic [NUM_MB-1:0] mb_err;
	logic [NUM_MB-1:0] mb_pend;
	logic [31:0] mode_word;
	logic [31:0] tx_word;
	logic [31:0] rd_mux;

	// ==========================================
	// register decode
	assign wr_ctrl = reg_wr && (reg_addr == cst_pkg::OFS_MAIN_CTRL);
	assign wr_mode = reg_wr && (reg_addr == cst_pkg::OFS_MODE_STATE);
	assign wr_tx = reg_wr && (reg_addr == cst_pkg::OFS_TX_STATE);
	assign wr_mask = reg_wr && (reg_addr == cst_pkg::OFS_IRQ_MASK);
	assign rd_stat = reg_rd && (reg_addr == cst_pkg::OFS_IRQ_STATUS);

	// start of frame: dominant edge on the receive pin while asleep
	assign sof_wake = (mode_q == cst_pkg::CST_SLEEP) && rx_level_q && !rx_pin;
	assign sleep_enter = (mode_d == cst_pkg::CST_SLEEP) && (mode_q != cst_pkg::CST_SLEEP);
	assign sleep_leave = (mode_d != cst_pkg::CST_SLEEP) && (mode_q == cst_pkg::CST_SLEEP);

	// ==========================================
	// main control, auto wakeup drops the sleep request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= cst_pkg::CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata & cst_pkg::CTRL_WR_MASK;
			end
			if (sof_wake && ctrl_q[cst_pkg::CTRL_AUTO_WAKEUP]) begin
				ctrl_q[cst_pkg::CTRL_SLEEP_REQUEST] <= 1'b0;
			end
		end
	end

	// ==========================================
	// operating mode
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			cst_pkg::CST_SLEEP: begin
				if (!ctrl_q[cst_pkg::CTRL_SLEEP_REQUEST]) begin
					mode_d = cst_pkg::CST_NORMAL;
					if (ctrl_q[cst_pkg::CTRL_INIT_REQUEST]) begin
						mode_d = cst_pkg::CST_INIT;
					end
				end
			end
			cst_pkg::CST_INIT: begin
				if (!ctrl_q[cst_pkg::CTRL_INIT_REQUEST]) begin
					mode_d = cst_pkg::CST_NORMAL;
					if (ctrl_q[cst_pkg::CTRL_SLEEP_REQUEST]) begin
						mode_d = cst_pkg::CST_SLEEP;
					end
				end
			end
			cst_pkg::CST_NORMAL: begin
				if (ctrl_q[cst_pkg::CTRL_INIT_REQUEST]) begin
					mode_d = cst_pkg::CST_INIT;
				end else if (ctrl_q[cst_pkg::CTRL_SLEEP_REQUEST]) begin
					mode_d = cst_pkg::CST_SLEEP;
				end
			end
			default: begin
				mode_d = cst_pkg::CST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= cst_pkg::CST_SLEEP;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_mode <= 1'b0;
		end else begin
			init_mode <= (mode_d == cst_pkg::CST_INIT);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_mode <= 1'b1;
		end else begin
			sleep_mode <= (mode_d == cst_pkg::CST_SLEEP);
		end
	end

	// ==========================================
	// mode state flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_flag_q <= 1'b0;
		end else if (err_event) begin
			err_flag_q <= 1'b1;
		end else if (wr_mode && reg_wdata[cst_pkg::MS_ERROR_IRQ]) begin
			err_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_flag_q <= 1'b0;
		end else if (sof_wake) begin
			wake_flag_q <= 1'b1;
		end else if (wr_mode && reg_wdata[cst_pkg::MS_WAKEUP_IRQ]) begin
			wake_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_irq_q <= 1'b0;
		end else if (sleep_enter) begin
			sleep_irq_q <= 1'b1;
		end else if (sleep_leave || (wr_mode && reg_wdata[cst_pkg::MS_SLEEP_ENTRY_IRQ])) begin
			sleep_irq_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_now_q <= 1'b0;
		end else begin
			tx_now_q <= tx_active;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_now_q <= 1'b0;
		end else begin
			rx_now_q <= rx_active;
		end
	end

	// receive pin: recessive after reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_level_q <= 1'b1;
		end else begin
			rx_level_q <= rx_pin;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_last_q <= 1'b1;
		end else if (rx_sample) begin
			rx_last_q <= rx_pin;
		end
	end

	// ==========================================
	// transmit mailboxes
	for (genvar m = 0; m < NUM_MB; m++) begin : g_mb
		localparam int unsigned B = m * cst_pkg::TS_MB_STRIDE;
		logic abort_wr;
		logic clr_done;
		logic clr_ok;
		logic clr_arb;
		logic clr_err;
		assign abort_wr = wr_tx && reg_wdata[B + cst_pkg::TS_ABORT_REQUEST];
		assign clr_done = wr_tx && reg_wdata[B + cst_pkg::TS_REQUEST_DONE];
		assign clr_ok = wr_tx && reg_wdata[B + cst_pkg::TS_TX_OK];
		assign clr_arb = wr_tx && reg_wdata[B + cst_pkg::TS_ARB_LOST];
		assign clr_err = wr_tx && reg_wdata[B + cst_pkg::TS_TX_FAILED];
		cst_mailbox u_mb (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.new_req(mb_new_req[m]),
			.ok_evt(mb_ok[m]),
			.fail_evt(mb_fail[m]),
			.arb_evt(mb_arb_lost[m]),
			.abort_done(mb_abort_done[m]),
			.abort_wr(abort_wr),
			.clr_done(clr_done),
			.clr_ok(clr_ok),
			.clr_arb(clr_arb),
			.clr_err(clr_err),
			.done_q(mb_done[m]),
			.ok_q(mb_okf[m]),
			.arb_q(mb_arb[m]),
			.err_q(mb_err[m]),
			.abort_q(mb_abort_req[m]),
			.pending_q(mb_pend[m])
		);
	end

	// ==========================================
	// status words, reserved bits zero
	always_comb begin
		mode_word = 32'h0000_0000;
		mode_word[cst_pkg::MS_INIT_MODE_ACK] = (mode_q == cst_pkg::CST_INIT);
		mode_word[cst_pkg::MS_SLEEP_MODE_ACK] = (mode_q == cst_pkg::CST_SLEEP);
		mode_word[cst_pkg::MS_ERROR_IRQ] = err_flag_q;
		mode_word[cst_pkg::MS_WAKEUP_IRQ] = wake_flag_q;
		mode_word[cst_pkg::MS_SLEEP_ENTRY_IRQ] = sleep_irq_q;
		mode_word[cst_pkg::MS_TRANSMITTING] = tx_now_q;
		mode_word[cst_pkg::MS_RECEIVING] = rx_now_q;
		mode_word[cst_pkg::MS_RX_LAST_SAMPLED] = rx_last_q;
		mode_word[cst_pkg::MS_RX_PIN_LEVEL] = rx_level_q;
	end

	always_comb begin
		tx_word = 32'h0000_0000;
		for (int unsigned i = 0; i < NUM_MB; i++) begin
			tx_word[i * cst_pkg::TS_MB_STRIDE + cst_pkg::TS_REQUEST_DONE] = mb_done[i];
			tx_word[i * cst_pkg::TS_MB_STRIDE + cst_pkg::TS_TX_OK] = mb_okf[i];
			tx_word[i * cst_pkg::TS_MB_STRIDE + cst_pkg::TS_ARB_LOST] = mb_arb[i];
			tx_word[i * cst_pkg::TS_MB_STRIDE + cst_pkg::TS_TX_FAILED] = mb_err[i];
			tx_word[i * cst_pkg::TS_MB_STRIDE + cst_pkg::TS_ABORT_REQUEST] = mb_abort_req[i];
			tx_word[cst_pkg::TS_EMPTY_BASE + i] = !mb_pend[i];
		end
	end

	always_comb begin
		unique case (reg_addr)
			cst_pkg::OFS_MAIN_CTRL: rd_mux = ctrl_q;
			cst_pkg::OFS_MODE_STATE: rd_mux = mode_word;
			cst_pkg::OFS_TX_STATE: rd_mux = tx_word;
			cst_pkg::OFS_IRQ_STATUS: rd_mux = 32'(irq_stat_q);
			cst_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask_q);
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ==========================================
	// interrupts: sticky status, cleared by reading it
	always_comb begin
		irq_evt = '0;
		irq_evt[cst_pkg::IRQ_ERROR] = err_event;
		irq_evt[cst_pkg::IRQ_WAKEUP] = sof_wake;
		irq_evt[cst_pkg::IRQ_SLEEP_ENTRY] = sleep_enter;
		for (int unsigned i = 0; i < NUM_MB; i++) begin
			irq_evt[cst_pkg::IRQ_MB_DONE_BASE + i] = mb_ok[i] | mb_fail[i] | mb_abort_done[i];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (rd_stat) begin
			irq_stat_q <= irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= '0;
		end else if (wr_mask) begin
			irq_mask_q <= reg_wdata[cst_pkg::IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule

// *** cst_pkg.sv ***
package cst_pkg;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE_STATE = 8'h04;
	localparam logic [7:0] OFS_TX_STATE = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;

	// ==========================================
	// main_control_word fields
	localparam int unsigned CTRL_INIT_REQUEST = 0;
	localparam int unsigned CTRL_SLEEP_REQUEST = 1;
	localparam int unsigned CTRL_AUTO_WAKEUP = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
	localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0023;

	// ==========================================
	// mode_state_word fields
	localparam int unsigned MS_INIT_MODE_ACK = 0;
	localparam int unsigned MS_SLEEP_MODE_ACK = 1;
	localparam int unsigned MS_ERROR_IRQ = 2;
	localparam int unsigned MS_WAKEUP_IRQ = 3;
	localparam int unsigned MS_SLEEP_ENTRY_IRQ = 4;
	localparam int unsigned MS_TRANSMITTING = 8;
	localparam int unsigned MS_RECEIVING = 9;
	localparam int unsigned MS_RX_LAST_SAMPLED = 10;
	localparam int unsigned MS_RX_PIN_LEVEL = 11;
	localparam logic [31:0] MS_RESET = 32'h0000_0C02;

	// ==========================================
	// transmit_state_word fields, per mailbox at base + stride * index
	localparam int unsigned TS_MB_STRIDE = 8;
	localparam int unsigned TS_REQUEST_DONE = 0;
	localparam int unsigned TS_TX_OK = 1;
	localparam int unsigned TS_ARB_LOST = 2;
	localparam int unsigned TS_TX_FAILED = 3;
	localparam int unsigned TS_ABORT_REQUEST = 7;
	localparam int unsigned TS_EMPTY_BASE = 26;
	localparam logic [31:0] TS_RESET = 32'h1C00_0000;

	// ==========================================
	// interrupt status and mask layout
	localparam int unsigned IRQ_WIDTH = 6;
	localparam int unsigned IRQ_ERROR = 0;
	localparam int unsigned IRQ_WAKEUP = 1;
	localparam int unsigned IRQ_SLEEP_ENTRY = 2;
	localparam int unsigned IRQ_MB_DONE_BASE = 3;

	// ==========================================
	// controller operating mode
	typedef enum logic [1:0] {
		CST_SLEEP = 2'b00,
		CST_INIT = 2'b01,
		CST_NORMAL = 2'b11
	} cst_mode_t;
endpackage

// *** cst_mailbox.sv ***
`timescale 1ns/100ps
module cst_mailbox (
	input wire logic ref_clk, // peripheral clock
	input wire logic rst_n, // async reset, active low
	input wire logic new_req, // new transmit request pulse
	input wire logic ok_evt, // attempt succeeded pulse
	input wire logic fail_evt, // attempt failed, request ended
	input wire logic arb_evt, // arbitration lost pulse
	input wire logic abort_done, // core removed the message
	input wire logic abort_wr, // software wrote 1 to abort
	input wire logic clr_done, // write-1-to-clear strobes
	input wire logic clr_ok, // clear success flag
	input wire logic clr_arb, // clear arbitration lost flag
	input wire logic clr_err, // clear failure flag
	output logic done_q, // request completed
	output logic ok_q, // last attempt succeeded
	output logic arb_q, // arbitration lost
	output logic err_q, // transmission failed
	output logic abort_q, // abort request pending
	output logic pending_q // message awaiting transmission
);
	logic finish;

	assign finish = ok_evt | fail_evt | abort_done;

	// ==========================================
	// message occupancy
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
		end else if (new_req) begin
			pending_q <= 1'b1;
		end else if (finish) begin
			pending_q <= 1'b0;
		end
	end

	// ==========================================
	// request completed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (new_req || clr_done) begin
			done_q <= 1'b0;
		end
	end

	// ==========================================
	// success
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ok_q <= 1'b0;
		end else if (ok_evt) begin
			ok_q <= 1'b1;
		end else if (fail_evt || clr_ok) begin
			ok_q <= 1'b0;
		end
	end

	// ==========================================
	// arbitration lost
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_q <= 1'b0;
		end else if (arb_evt) begin
			arb_q <= 1'b1;
		end else if (clr_arb) begin
			arb_q <= 1'b0;
		end
	end

	// ==========================================
	// failure
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= 1'b0;
		end else if (fail_evt) begin
			err_q <= 1'b1;
		end else if (clr_err) begin
			err_q <= 1'b0;
		end
	end

	// ==========================================
	// abort request, only while a message waits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_q <= 1'b0;
		end else if (finish) begin
			abort_q <= 1'b0;
		end else if (abort_wr && pending_q) begin
			abort_q <= 1'b1;
		end
	end
endmodule

// *** cst_status_properties.sv ***
`timescale 1ns/100ps
module cst_status_checker #(
	parameter int unsigned NUM_MB = 3 // transmit mailboxes
) (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic [7:0] reg_addr, // address
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic err_event, // error event
	input wire logic [NUM_MB-1:0] mb_ok, // success pulse
	input wire logic [NUM_MB-1:0] mb_fail, // failure pulse
	input wire logic [NUM_MB-1:0] mb_abort_done, // message removed
	input wire logic [NUM_MB-1:0] mb_abort_req, // abort request
	input wire logic init_mode, // init state
	input wire logic sleep_mode // sleep state
);
	wire logic rd_ms = reg_rd && reg_addr == cst_pkg::OFS_MODE_STATE;
	wire logic rd_ts = reg_rd && reg_addr == cst_pkg::OFS_TX_STATE;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ====
	// status words
	mode_ack_a: assert property (
		rd_ms |=> reg_rdata[1:0] == {$past(sleep_mode), $past(init_mode)})
		else $error("mode ack bits wrong");
	mode_excl_a: assert property (!(init_mode && sleep_mode))
		else $error("init and sleep together");
	mode_rsvd_a: assert property (rd_ms |=> (reg_rdata & 32'hFFFF_F0E0) == 32'h0)
		else $error("mode reserved bits set");
	tx_rsvd_a: assert property (rd_ts |=> (reg_rdata & 32'hE370_7070) == 32'h0)
		else $error("tx reserved bits set");
	err_set_a: assert property (err_event ##1 rd_ms |=> reg_rdata[2])
		else $error("error flag missing");
	done_ok_a: assert property (
		mb_ok[0] ##1 rd_ts |=> reg_rdata[1:0] == 2'h3 && reg_rdata[26])
		else $error("success flags missing");
	fail_err_a: assert property (mb_fail[0] ##1 rd_ts |=> reg_rdata[3] && !reg_rdata[1])
		else $error("failure flags wrong");
	abort_end_a: assert property (mb_abort_done[0] |=> !mb_abort_req[0])
		else $error("abort request stuck");
endmodule

bind cst_status_top cst_status_checker #(.NUM_MB(NUM_MB)) i_cst_status_checker (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.err_event(err_event),
	.mb_ok(mb_ok),
	.mb_fail(mb_fail),
	.mb_abort_done(mb_abort_done),
	.mb_abort_req(mb_abort_req),
	.init_mode(init_mode),
	.sleep_mode(sleep_mode)
);

// *** cst_core_model.sv ***
`timescale 1ns/100ps
module cst_core_model (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic cmd_go, // start a transfer
	input wire logic [1:0] cmd_mb, // mailbox
	input wire logic [1:0] cmd_kind, // 0 ok, 1 fail, 2 arb then ok, 3 wait abort
	input wire logic [3:0] cmd_wait, // cycles to outcome
	input wire logic [2:0] mb_abort_req, // abort from block
	output logic [2:0] mb_new_req, // request pulse
	output logic [2:0] mb_ok, // success pulse
	output logic [2:0] mb_fail, // failure pulse
	output logic [2:0] mb_arb_lost, // arbitration lost pulse
	output logic [2:0] mb_abort_done, // message removed
	output logic tx_active, // on the bus
	output logic busy // transfer open
);
	logic [3:0] cnt_q;
	logic [1:0] mb_q;
	logic [1:0] kind_q;
	// ====
	// transfer sequencing
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mb_new_req <= 3'h0;
			mb_ok <= 3'h0;
			mb_fail <= 3'h0;
			mb_arb_lost <= 3'h0;
			mb_abort_done <= 3'h0;
			tx_active <= 1'b0;
			busy <= 1'b0;
			cnt_q <= 4'h0;
			mb_q <= 2'h0;
			kind_q <= 2'h0;
		end else begin
			mb_new_req <= 3'h0;
			mb_ok <= 3'h0;
			mb_fail <= 3'h0;
			mb_arb_lost <= 3'h0;
			mb_abort_done <= 3'h0;
			if (cmd_go && !busy) begin
				mb_new_req[cmd_mb] <= 1'b1;
				busy <= 1'b1;
				mb_q <= cmd_mb;
				kind_q <= cmd_kind;
				cnt_q <= cmd_wait;
			end else if (busy && mb_abort_req[mb_q]) begin
				mb_abort_done[mb_q] <= 1'b1;
				busy <= 1'b0;
				tx_active <= 1'b0;
			end else if (busy) begin
				tx_active <= 1'b1;
				if (cnt_q != 4'h0) begin
					cnt_q <= cnt_q - 4'h1;
				end else if (kind_q == 2'h2) begin
					mb_arb_lost[mb_q] <= 1'b1;
					kind_q <= 2'h0;
					cnt_q <= 4'h3;
				end else if (kind_q != 2'h3) begin
					mb_ok[mb_q] <= (kind_q == 2'h0);
					mb_fail[mb_q] <= (kind_q == 2'h1);
					busy <= 1'b0;
					tx_active <= 1'b0;
				end
			end
		end
	end
endmodule

// *** test_cst_status_top.sv ***
`timescale 1ns/100ps
module test_cst_status_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rx_pin = 1'b1;
	logic rx_sample = 1'b0;
	logic err_event = 1'b0;
	logic rx_active = 1'b0;
	logic cmd_go = 1'b0;
	logic [1:0] cmd_mb = 2'h0;
	logic [1:0] cmd_kind = 2'h0;
	logic [3:0] cmd_wait = 4'h0;
	logic [31:0] reg_rdata, rd_q, tsw;
	logic [2:0] mb_new_req, mb_ok, mb_fail, mb_arb_lost, mb_abort_done, mb_abort_req;
	logic irq, tx_active, busy;
	logic [31:0] seed = 32'h2ECE35FB;
	logic [5:0] irq_exp = 6'h07;
	int fails = 0;
	int tests_run = 0;
	always #50 ref_clk = ~ref_clk;
	cst_status_top #(.NUM_MB(3)) i_cst_status_top (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .rx_pin(rx_pin), .rx_sample(rx_sample),
		.err_event(err_event), .tx_active(tx_active), .rx_active(rx_active),
		.mb_new_req(mb_new_req), .mb_ok(mb_ok), .mb_fail(mb_fail), .mb_arb_lost(mb_arb_lost),
		.mb_abort_done(mb_abort_done), .mb_abort_req(mb_abort_req), .init_mode(), .sleep_mode());
	cst_core_model i_cst_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_go(cmd_go),
		.cmd_mb(cmd_mb), .cmd_kind(cmd_kind), .cmd_wait(cmd_wait), .mb_abort_req(mb_abort_req),
		.mb_new_req(mb_new_req), .mb_ok(mb_ok), .mb_fail(mb_fail), .mb_arb_lost(mb_arb_lost),
		.mb_abort_done(mb_abort_done), .tx_active(tx_active), .busy(busy));
	// ====
	// helpers
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] after_xfer(input logic [31:0] w, input int m,
		input logic [1:0] k);
		w[8*m] = 1'b1;
		if (k == 2'h0 || k == 2'h2) w[8*m+1] = 1'b1;
		if (k == 2'h1) w[8*m+1] = 1'b0;
		if (k == 2'h1) w[8*m+3] = 1'b1;
		if (k == 2'h2) w[8*m+2] = 1'b1;
		return w;
	endfunction
	task automatic tally_and_finish();
		if (fails == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
		chk(what, exp, rd_q);
		@(posedge ref_clk);
	endtask
	task automatic ctl(input logic [31:0] d);
		wr(cst_pkg::OFS_MAIN_CTRL, d);
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic irq_chk(input logic e);
		repeat (2) @(negedge ref_clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge ref_clk);
	endtask
	task automatic xfer(input int m, input logic [1:0] k, input logic [3:0] w);
		int n;
		cmd_go <= 1'b1;
		cmd_mb <= 2'(m);
		cmd_kind <= k;
		cmd_wait <= w;
		rx_active <= seed[7];
		@(posedge ref_clk);
		cmd_go <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rchk("mode busy", cst_pkg::OFS_MODE_STATE, {20'h0, 2'h3, seed[7], 1'b1, 8'h00});
		chk("activity", {30'h0, seed[7], 1'b1}, {30'h0, rd_q[9:8]});
		rchk("tx pend", cst_pkg::OFS_TX_STATE, tsw & ~(32'h1 << (8*m)) & ~(32'h1 << (26+m)));
		if (k == 2'h3) wr(cst_pkg::OFS_TX_STATE, 32'h80 << (8*m));
		n = 0;
		while (busy !== 1'b0 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 60) begin
			fails++;
			tally_and_finish();
		end
		@(posedge ref_clk);
		tsw = after_xfer(tsw, m, k);
		rchk("tx done", cst_pkg::OFS_TX_STATE, tsw);
		irq_exp[3+m] = 1'b1;
	endtask
	// ====
	// main sequence
	initial begin
		tsw = cst_pkg::TS_RESET;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rchk("mode rst", cst_pkg::OFS_MODE_STATE, cst_pkg::MS_RESET);
		rchk("tx rst", cst_pkg::OFS_TX_STATE, cst_pkg::TS_RESET);
		rchk("unmapped", 8'h10, 32'h0);
		ctl(32'h0);
		rchk("normal", cst_pkg::OFS_MODE_STATE, 32'h0000_0C00);
		ctl(32'h1);
		rchk("init", cst_pkg::OFS_MODE_STATE, 32'h0000_0C01);
		ctl(32'h0);
		rchk("init left", cst_pkg::OFS_MODE_STATE, 32'h0000_0C00);
		err_event <= 1'b1;
		@(posedge ref_clk);
		err_event <= 1'b0;
		rchk("err set", cst_pkg::OFS_MODE_STATE, 32'h0000_0C04);
		wr(cst_pkg::OFS_MODE_STATE, 32'hFFFF_FFFB);
		rchk("zero wr", cst_pkg::OFS_MODE_STATE, 32'h0000_0C04);
		err_event <= 1'b1;
		wr(cst_pkg::OFS_MODE_STATE, 32'h4);
		err_event <= 1'b0;
		rchk("set wins", cst_pkg::OFS_MODE_STATE, 32'h0000_0C04);
		wr(cst_pkg::OFS_MODE_STATE, 32'h4);
		rchk("err clr", cst_pkg::OFS_MODE_STATE, 32'h0000_0C00);
		ctl(32'h2);
		rchk("sleep", cst_pkg::OFS_MODE_STATE, 32'h0000_0C12);
		rx_pin <= 1'b0;
		rx_sample <= 1'b1;
		@(posedge ref_clk);
		rx_sample <= 1'b0;
		@(posedge ref_clk);
		rchk("wakeup", cst_pkg::OFS_MODE_STATE, 32'h0000_001A);
		wr(cst_pkg::OFS_MODE_STATE, 32'h8);
		rx_pin <= 1'b1;
		@(posedge ref_clk);
		rchk("pin only", cst_pkg::OFS_MODE_STATE, 32'h0000_0812);
		rx_sample <= 1'b1;
		@(posedge ref_clk);
		rx_sample <= 1'b0;
		ctl(32'h0);
		rchk("awake", cst_pkg::OFS_MODE_STATE, 32'h0000_0C00);
		ctl(32'h22);
		rx_pin <= 1'b0;
		@(posedge ref_clk);
		rx_pin <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rchk("auto wake", cst_pkg::OFS_MODE_STATE, 32'h0000_0C08);
		rchk("auto ctrl", cst_pkg::OFS_MAIN_CTRL, 32'h0000_0020);
		wr(cst_pkg::OFS_MODE_STATE, 32'h8);
		irq_chk(1'b0);
		wr(cst_pkg::OFS_IRQ_MASK, 32'h3F);
		irq_chk(1'b1);
		rchk("irq stat", cst_pkg::OFS_IRQ_STATUS, {26'h0, irq_exp});
		irq_chk(1'b0);
		irq_exp = 6'h0;
		xfer(0, 2'h0, 4'h8);
		xfer(0, 2'h1, 4'hF);
		xfer(0, 2'h3, 4'h8);
		for (int i = 0; i < 12; i++) begin
			seed = xorshift(seed);
			xfer(seed[1:0] % 3, seed[3:2], {1'b1, seed[6:4]});
		end
		rchk("irq mb", cst_pkg::OFS_IRQ_STATUS, {26'h0, irq_exp});
		wr(cst_pkg::OFS_TX_STATE, 32'h008F_8F8F);
		rchk("tx clr", cst_pkg::OFS_TX_STATE, cst_pkg::TS_RESET);
		tally_and_finish();
	end
endmodule
